/* File: design/ds3_params.svh */
`ifndef DS3_PARAMS_SVH
`define DS3_PARAMS_SVH
// Contract
// - status scan register mirrors three link pins
// - scan bit 2 shows drive monitor pin
// - scan bit 1 shows clock unlock pin
// - scan bit 0 shows signal loss pin
// - loss pin declares loss, flags change interrupt
// - mode bit 6 set selects DS3 operation
// - DS3 supports C-bit parity and M13 formats
// - M-frame 4760 bits: 56 overhead, 4704 payload
// - payload grouped into 84-bit packets
// - one overhead bit before each packet
// - overhead 2..8 carry F1 C F0 C F0 C F1
// - subframes 5,6,7 lead with M bits 010
// - subframes 1,2 lead X; 3,4 lead P
// - C-bit: AIC NA FEAC; UDL NA UDL
// - C-bit: subframe 3 C bits carry CP parity
// - C-bit: subframe 4 C bits carry FEBE
// - C-bit: subframe 5 DL, 6 and 7 UDL
// - mode bit 2: 0 C-bit parity, 1 M13
// - seven 680-bit subframes of eight 85-bit blocks

// ****************************************************
// register map
// ****************************************************
`define MODE_OFS 8'h00
`define SCAN_OFS 8'h81
`define MODE_RST 8'h00
`define MODE_DS3_BIT 6
`define MODE_FMT_BIT 2
`define SCAN_DM_BIT 2
`define SCAN_UNLOCK_BIT 1
`define SCAN_LOSS_BIT 0

// ****************************************************
// frame geometry
// ****************************************************
`define FRAME_BITS 4760
`define OH_BITS 56
`define PAYLOAD_BITS 4704
`define PKT_BITS 84
`define BIT_LAST 7'h54
`define BLK_LAST 3'h7
`define SF_LAST 3'h6
`define WORD_W 8
`define FIFO_DEPTH 8
`endif

/* File: design/ds3_types_pkg.sv */
package ds3_types_pkg;
   typedef enum logic {FMT_CBIT, FMT_M13} ds3_format_e;
endpackage

/* File: design/line_sync.sv */
// ****************************************************
// two-flop synchroniser, one chain per bit
// ****************************************************
module line_sync #(
   parameter int W = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_chain
         logic meta_q;
         logic out_q;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               meta_q <= 1'b0;
               out_q <= 1'b0;
            end else begin
               meta_q <= async_i[g];
               out_q <= meta_q;
            end
         end
         assign sync_o[g] = out_q;
      end
   endgenerate
endmodule

/* File: design/pay_fifo.sv */
// ****************************************************
// payload fifo
// ****************************************************
module pay_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rp_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_ready_i && out_valid_o;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wp_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

/* File: design/ds3_framer_status.sv */
`include "ds3_params.svh"
module ds3_framer_status (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic drive_monitor_status_i,
   input wire logic recovered_clock_unlock_i,
   input wire logic line_signal_loss_i,
   output logic los_declared_o,
   output logic los_change_irq_o,
   output logic ds3_not_e3_select_o,
   output logic m13_select_o,
   output logic [1:0] timing_reference_select_o,
   input wire logic [7:0] pay_data_i,
   input wire logic pay_valid_i,
   output logic pay_ready_o,
   input wire logic x_bit_i,
   input wire logic feac_bit_i,
   input wire logic febe_bit_i,
   input wire logic dl_bit_i,
   input wire logic udl_bit_i,
   input wire logic [6:0] stuff_ctl_i,
   input wire logic tx_bit_en_i,
   output logic tx_data_o,
   output logic tx_oh_o,
   output logic tx_frame_start_o,
   output logic tx_underrun_o
);
   // ****************************************************
   // status pins
   // ****************************************************
   logic [2:0] pins;
   logic [2:0] st;
   logic loss_prev_q;
   logic loss_chg_q;
   logic rd_scan;

   assign pins = {drive_monitor_status_i, recovered_clock_unlock_i,
                  line_signal_loss_i};

   line_sync #(.W(3)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(pins),
      .sync_o(st)
   );

   assign rd_scan = rd_i && (addr_i == `SCAN_OFS);
   assign los_declared_o = st[`SCAN_LOSS_BIT];
   assign los_change_irq_o = loss_chg_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loss_prev_q <= 1'b0;
      end else begin
         loss_prev_q <= st[`SCAN_LOSS_BIT];
      end
   end

   // change flag; a new change wins over the read that clears it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loss_chg_q <= 1'b0;
      end else if (st[`SCAN_LOSS_BIT] != loss_prev_q) begin
         loss_chg_q <= 1'b1;
      end else if (rd_scan) begin
         loss_chg_q <= 1'b0;
      end
   end

   // ****************************************************
   // registers
   // ****************************************************
   logic [7:0] mode_q;
   ds3_types_pkg::ds3_format_e fmt;
   logic ds3_on;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= `MODE_RST;
      end else if (wr_i && addr_i == `MODE_OFS) begin
         mode_q <= wdata_i;
      end
   end

   assign ds3_on = mode_q[`MODE_DS3_BIT];
   assign fmt = mode_q[`MODE_FMT_BIT] ? ds3_types_pkg::FMT_M13
                                       : ds3_types_pkg::FMT_CBIT;
   assign ds3_not_e3_select_o = ds3_on;
   assign m13_select_o = mode_q[`MODE_FMT_BIT];
   assign timing_reference_select_o = mode_q[1:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            `MODE_OFS: rdata_o <= mode_q;
            `SCAN_OFS: rdata_o <= {5'h00, st};
            default: rdata_o <= 8'h00;
         endcase
      end
   end

   // ****************************************************
   // M-frame position
   // ****************************************************
   logic [6:0] bit_q;
   logic [2:0] blk_q;
   logic [2:0] sf_q;
   logic adv;

   assign adv = tx_bit_en_i && ds3_on;

   always_ff @(posedge clk_i) begin
      if (rst_i || !ds3_on) begin
         bit_q <= 7'h00;
         blk_q <= 3'h0;
         sf_q <= 3'h0;
      end else if (adv) begin
         if (bit_q != `BIT_LAST) begin
            bit_q <= bit_q + 7'h01;
         end else begin
            bit_q <= 7'h00;
            if (blk_q != `BLK_LAST) begin
               blk_q <= blk_q + 3'h1;
            end else begin
               blk_q <= 3'h0;
               sf_q <= (sf_q == `SF_LAST) ? 3'h0 : sf_q + 3'h1;
            end
         end
      end
   end

   // ****************************************************
   // overhead bit selection
   // ****************************************************
   logic oh_bit;
   logic [1:0] c_idx;
   logic par_q;
   logic par_acc_q;

   always_comb begin
      c_idx = 2'(blk_q[2:1] - 2'h1);
      oh_bit = 1'b0;
      case (blk_q)
         3'h0: begin
            if (sf_q < 3'h2) begin
               oh_bit = x_bit_i;
            end else if (sf_q < 3'h4) begin
               oh_bit = par_q;
            end else begin
               oh_bit = (sf_q == 3'h5);
            end
         end
         3'h1, 3'h7: oh_bit = 1'b1;
         3'h3, 3'h5: oh_bit = 1'b0;
         default: begin
            if (fmt == ds3_types_pkg::FMT_M13) begin
               oh_bit = stuff_ctl_i[sf_q];
            end else begin
               case (sf_q)
                  3'h0: oh_bit = (c_idx == 2'h2) ? feac_bit_i : 1'b1;
                  3'h1: oh_bit = (c_idx == 2'h1) ? 1'b1 : udl_bit_i;
                  3'h2: oh_bit = par_q;
                  3'h3: oh_bit = febe_bit_i;
                  3'h4: oh_bit = dl_bit_i;
                  default: oh_bit = udl_bit_i;
               endcase
            end
         end
      endcase
   end

   // ****************************************************
   // payload path
   // ****************************************************
   logic [7:0] f_data;
   logic f_valid;
   logic f_ready;
   logic [7:0] sh_q;
   logic [3:0] sh_cnt_q;
   logic pay_slot;
   logic pay_bit;

   pay_fifo #(.W(`WORD_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_data_i(pay_data_i),
      .in_valid_i(pay_valid_i),
      .in_ready_o(pay_ready_o),
      .out_data_o(f_data),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready)
   );

   assign pay_slot = adv && (bit_q != 7'h00);
   assign f_ready = pay_slot && (sh_cnt_q == 4'h0);
   assign pay_bit = (sh_cnt_q != 4'h0) ? sh_q[7] : (f_valid && f_data[7]);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh_q <= 8'h00;
         sh_cnt_q <= 4'h0;
      end else if (pay_slot) begin
         if (sh_cnt_q != 4'h0) begin
            sh_q <= {sh_q[6:0], 1'b0};
            sh_cnt_q <= sh_cnt_q - 4'h1;
         end else if (f_valid) begin
            sh_q <= {f_data[6:0], 1'b0};
            sh_cnt_q <= 4'h7;
         end
      end
   end

   // P and CP carry the parity of the previous frame's payload
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         par_acc_q <= 1'b0;
         par_q <= 1'b0;
      end else if (adv && bit_q == `BIT_LAST && blk_q == `BLK_LAST &&
                   sf_q == `SF_LAST) begin
         par_q <= par_acc_q ^ pay_bit;
         par_acc_q <= 1'b0;
      end else if (pay_slot) begin
         par_acc_q <= par_acc_q ^ pay_bit;
      end
   end

   // ****************************************************
   // line output
   // ****************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_data_o <= 1'b0;
         tx_oh_o <= 1'b0;
         tx_frame_start_o <= 1'b0;
      end else if (adv) begin
         tx_data_o <= (bit_q == 7'h00) ? oh_bit : pay_bit;
         tx_oh_o <= (bit_q == 7'h00);
         tx_frame_start_o <= (bit_q == 7'h00) && (blk_q == 3'h0) &&
                             (sf_q == 3'h0);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_underrun_o <= 1'b0;
      end else begin
         tx_underrun_o <= f_ready && !f_valid;
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   property p_scan_bits;
      @(posedge clk_i) disable iff (rst_i)
      rd_scan |=> rdata_o == {5'h00, $past(st)};
   endproperty
   a_scan_bits: assert property (p_scan_bits)
      else $error("scan register does not mirror status pins");

   property p_sync;
      @(posedge clk_i) disable iff (rst_i)
      ##2 st == $past(pins, 2);
   endproperty
   a_sync: assert property (p_sync)
      else $error("status pin latency is not two cycles");

   property p_los_irq;
      @(posedge clk_i) disable iff (rst_i)
      $changed(los_declared_o) |=> los_change_irq_o;
   endproperty
   a_los_irq: assert property (p_los_irq)
      else $error("loss change did not raise interrupt flag");

   property p_ds3_sel;
      @(posedge clk_i) disable iff (rst_i)
      wr_i && addr_i == `MODE_OFS |=>
         ds3_not_e3_select_o == $past(wdata_i[`MODE_DS3_BIT]) &&
         m13_select_o == $past(wdata_i[`MODE_FMT_BIT]);
   endproperty
   a_ds3_sel: assert property (p_ds3_sel)
      else $error("mode write did not select mode and format");

   property p_wrap;
      @(posedge clk_i) disable iff (rst_i)
      adv && bit_q == `BIT_LAST && blk_q == `BLK_LAST && sf_q == `SF_LAST
         |=> bit_q == 7'h00 && blk_q == 3'h0 && sf_q == 3'h0;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("M-frame did not wrap after last bit");

   property p_oh_flag;
      @(posedge clk_i) disable iff (rst_i)
      adv |=> tx_oh_o == ($past(bit_q) == 7'h00);
   endproperty
   a_oh_flag: assert property (p_oh_flag)
      else $error("overhead marker misplaced");

   property p_fbits;
      @(posedge clk_i) disable iff (rst_i)
      adv && bit_q == 7'h00 && blk_q[0] |=>
         tx_data_o == ($past(blk_q) == 3'h1 || $past(blk_q) == 3'h7);
   endproperty
   a_fbits: assert property (p_fbits)
      else $error("F bit value wrong");

   property p_mbits;
      @(posedge clk_i) disable iff (rst_i)
      adv && bit_q == 7'h00 && blk_q == 3'h0 && sf_q > 3'h3 |=>
         tx_data_o == ($past(sf_q) == 3'h5);
   endproperty
   a_mbits: assert property (p_mbits)
      else $error("M bit value wrong");

   property p_m13;
      @(posedge clk_i) disable iff (rst_i)
      adv && bit_q == 7'h00 && blk_q == 3'h2 && m13_select_o |=>
         tx_data_o == $past(stuff_ctl_i[sf_q]);
   endproperty
   a_m13: assert property (p_m13)
      else $error("M13 C bit is not stuff control");

   property p_cp;
      @(posedge clk_i) disable iff (rst_i)
      adv && bit_q == 7'h00 && blk_q == 3'h4 && sf_q == 3'h2 &&
         !m13_select_o |=> tx_data_o == $past(par_q);
   endproperty
   a_cp: assert property (p_cp)
      else $error("CP bit does not carry parity");
endmodule

/* File: tb/liu_model.sv */
// ****
// line unit status pins
// ****
module liu_model (
   input wire logic silent_i,
   input wire logic unlocked_i,
   input wire logic los_i,
   output logic drive_monitor_status_o,
   output logic recovered_clock_unlock_o,
   output logic line_signal_loss_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // levels follow the line conditions the bench commands
   assign drive_monitor_status_o = silent_i;
   assign recovered_clock_unlock_o = unlocked_i;
   assign line_signal_loss_o = los_i;
endmodule

/* File: tb/ds3_framer_status_test.sv */
`include "ds3_params.svh"
module ds3_framer_status_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i, rst_i, wr_i, rd_i, pay_valid_i, tx_bit_en_i, x_bit_i;
   logic feac_bit_i, febe_bit_i, dl_bit_i, udl_bit_i;
   logic [7:0] addr_i, wdata_i, pay_data_i, rdata_o, pb, got;
   logic [6:0] stuff_ctl_i;
   logic [2:0] cmd;
   logic [1:0] tsel;
   logic dm, unl, los, los_decl, irq, ds3, m13, ready;
   logic tx_data_o, tx_oh_o, tx_frame_start_o, tx_underrun_o;
   logic par_prev, par_run;
   int bi, errors, compares;

   liu_model line_unit (.silent_i(cmd[2]), .unlocked_i(cmd[1]),
      .los_i(cmd[0]), .drive_monitor_status_o(dm),
      .recovered_clock_unlock_o(unl), .line_signal_loss_o(los));

   ds3_framer_status dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .drive_monitor_status_i(dm), .recovered_clock_unlock_i(unl),
      .line_signal_loss_i(los), .los_declared_o(los_decl),
      .los_change_irq_o(irq), .ds3_not_e3_select_o(ds3),
      .m13_select_o(m13), .timing_reference_select_o(tsel),
      .pay_data_i(pay_data_i), .pay_valid_i(pay_valid_i),
      .pay_ready_o(ready), .x_bit_i(x_bit_i), .feac_bit_i(feac_bit_i),
      .febe_bit_i(febe_bit_i), .dl_bit_i(dl_bit_i), .udl_bit_i(udl_bit_i),
      .stuff_ctl_i(stuff_ctl_i), .tx_bit_en_i(tx_bit_en_i),
      .tx_data_o(tx_data_o), .tx_oh_o(tx_oh_o),
      .tx_frame_start_o(tx_frame_start_o), .tx_underrun_o(tx_underrun_o));

   // ****
   // shared tasks
   // ****
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: byte %h want %h", $time, g, e);
      end
   endtask

   task automatic chk_bit(input logic g, input logic e, input string what);
      compares++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: %s is %b", $time, what, g);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      wr_i = 1;
      addr_i = a;
      wdata_i = d;
      @(posedge clk_i);
      #1 wr_i = 0;
      @(posedge clk_i);
      #1;
   endtask

   task automatic reg_rd(input logic [7:0] a);
      rd_i = 1;
      addr_i = a;
      @(posedge clk_i);
      #1 rd_i = 0;
      got = rdata_o;
      @(posedge clk_i);
      #1;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // c-bit parity use of the stuff positions
   function automatic logic c_bit(input int sf, input int bl);
      case (sf)
         0: c_bit = (bl == 6) ? feac_bit_i : 1'b1;
         1: c_bit = (bl == 4) ? 1'b1 : udl_bit_i;
         2: c_bit = par_prev;
         3: c_bit = febe_bit_i;
         4: c_bit = dl_bit_i;
         default: c_bit = udl_bit_i;
      endcase
   endfunction

   // byte source: next value after each accepted byte
   always @(posedge clk_i) begin
      if (pay_valid_i && ready) begin
         #1 pay_data_i = pay_data_i + 8'h01;
      end
   end

   task automatic stream(input int n, input logic fmt);
      int k, pos, sf, bl;
      logic e;
      x_bit_i = ~fmt;
      tx_bit_en_i = 1;
      for (k = 0; k < n * 4760; k++) begin
         @(posedge clk_i);
         #1;
         pos = k % 4760;
         sf = pos / 680;
         bl = (pos % 680) / 85;
         if (pos == 0) begin
            par_prev = par_run;
            par_run = 0;
         end
         if (pos % 85 != 0) begin
            e = pb[7 - bi];
            par_run ^= e;
            bi++;
            if (bi == 8) begin
               bi = 0;
               pb++;
            end
         end else if (bl == 0) begin
            e = (sf < 2) ? x_bit_i : (sf < 4) ? par_prev : (sf == 5);
         end else if (bl % 2 == 1) begin
            e = (bl == 1 || bl == 7);
         end else if (fmt) begin
            e = stuff_ctl_i[sf];
         end else begin
            e = c_bit(sf, bl);
         end
         chk_bit(tx_data_o, e, "line bit");
         chk_bit(tx_oh_o, pos % 85 == 0, "oh flag");
         chk_bit(tx_frame_start_o, pos == 0, "start");
         chk_bit(tx_underrun_o, 1'b0, "underrun");
      end
   endtask

   // ****
   // scenarios and run control
   // ****
   task automatic t_reset();
      reg_rd(`MODE_OFS);
      chk_byte(got, 8'h00);
      reg_rd(`SCAN_OFS);
      chk_byte(got, 8'h00);
      chk_bit(ready, 1'b1, "ready");
      tx_bit_en_i = 1;
      wait_n(20);
      tx_bit_en_i = 0;
      chk_bit(tx_oh_o | tx_frame_start_o, 1'b0, "idle line");
   endtask

   task automatic t_regs();
      reg_wr(`MODE_OFS, 8'h44);
      reg_rd(`MODE_OFS);
      chk_byte(got, 8'h44);
      chk_bit(ds3 & m13, 1'b1, "ds3 m13");
      reg_wr(`MODE_OFS, 8'h43);
      chk_bit(m13, 1'b0, "m13");
      chk_byte({6'h00, tsel}, 8'h03);
      reg_wr(`SCAN_OFS, 8'hff);
      reg_rd(`SCAN_OFS);
      chk_byte(got, 8'h00);
      reg_wr(8'h10, 8'hff);
      reg_rd(8'h10);
      chk_byte(got, 8'h00);
      reg_rd(`MODE_OFS);
      chk_byte(got, 8'h43);
   endtask

   task automatic t_scan();
      logic [2:0] tbl [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
      logic prev;
      prev = 0;
      foreach (tbl[i]) begin
         cmd = tbl[i];
         wait_n(4);
         chk_bit(los_decl, cmd[0], "los");
         chk_bit(irq, cmd[0] ^ prev, "irq");
         prev = cmd[0];
         reg_rd(`SCAN_OFS);
         chk_byte(got, {5'h00, cmd});
         chk_bit(irq, 1'b0, "irq clear");
      end
   endtask

   task automatic t_frames();
      int w;
      reg_wr(`MODE_OFS, 8'h40);
      pay_valid_i = 1;
      for (w = 0; w < 50 && ready; w++) wait_n(1);
      chk_bit(ready, 1'b0, "fifo full");
      stream(2, 1'b0);
      tx_bit_en_i = 0;
      reg_wr(`MODE_OFS, 8'h44);
      stream(1, 1'b1);
      pay_valid_i = 0;
      for (w = 0; w < 200 && !tx_underrun_o; w++) wait_n(1);
      chk_bit(tx_underrun_o, 1'b1, "underrun seen");
      chk_bit(tx_data_o, 1'b0, "zero fill");
      tx_bit_en_i = 0;
   endtask

   task automatic close_out();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      clk_i = 0;
      forever #2 clk_i = ~clk_i;
   end

   initial begin
      #200000;
      errors++;
      close_out();
   end

   initial begin
      {wr_i, rd_i, pay_valid_i, tx_bit_en_i, x_bit_i, feac_bit_i} = 0;
      {febe_bit_i, dl_bit_i, udl_bit_i} = 3'h6;
      {addr_i, wdata_i, pay_data_i, pb} = 0;
      stuff_ctl_i = 7'h35;
      {cmd, par_prev, par_run, bi, errors, compares} = 0;
      rst_i = 1;
      repeat (16) @(posedge clk_i);
      #1 rst_i = 0;
      t_reset();
      t_regs();
      t_scan();
      t_frames();
      close_out();
   end
endmodule
